// [rtl/dtp_config.sv]
// control word decode for drive strength, termination and power saving
`include "dtp_consts.svh"
module dtp_config (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // control word write, from the command inputs
  input wire logic cw_write,
  input wire logic [3:0] cw_addr,
  input wire logic cw_data_bit0,
  input wire logic cw_data_bit1,
  input wire logic cw_data_bit2,
  input wire logic cw_data_bit3,
  // pins
  input wire logic mirror,
  input wire logic clock_enable_in_0,
  input wire logic clock_enable_in_1,
  input wire logic term_enable_input_pins,
  // drive strengths
  output dtp_pkg::dtp_drive_t ca_drive_a,
  output dtp_pkg::dtp_drive_t ca_drive_b,
  output dtp_pkg::dtp_drive_t ctl_drive_a,
  output dtp_pkg::dtp_drive_t ctl_drive_b,
  output dtp_pkg::dtp_drive_t clk_drive_13,
  output dtp_pkg::dtp_drive_t clk_drive_02,
  // termination
  output dtp_pkg::dtp_term_t term_value,
  output logic term_main_en,
  output logic term_sel_odt_en,
  // output modes
  output logic ca_prelaunch,
  output logic ca_float_idle,
  output logic weak_drive,
  output logic power_down,
  output logic term_enable_outputs
);
  import dtp_pkg::*;

  // stored words
  logic [3:0] w_glb, w_tim, w_ca, w_ctl, w_ck, w_xt, w_pwr;
  wire [3:0] wdata = {cw_data_bit3, cw_data_bit2, cw_data_bit1, cw_data_bit0};

  // address decode for word selects
  wire sel_glb = cw_write && (cw_addr == `DTP_ADDR_GLOBAL);
  wire sel_tim = cw_write && (cw_addr == `DTP_ADDR_TIMING);
  wire sel_ca = cw_write && (cw_addr == `DTP_ADDR_CA_DRV);
  wire sel_ctl = cw_write && (cw_addr == `DTP_ADDR_CTL_DRV);
  wire sel_ck = cw_write && (cw_addr == `DTP_ADDR_CK_DRV);
  wire sel_xt = cw_write && (cw_addr == `DTP_ADDR_XTERM);
  wire sel_pwr = cw_write && (cw_addr == `DTP_ADDR_PWR);

  // word storage
  dtp_word_reg u_glb (.core_clk(core_clk), .rstn(rstn), .clk_en(clk_en), .wr(sel_glb),
    .wdata(wdata), .word(w_glb));
  dtp_word_reg u_tim (.core_clk(core_clk), .rstn(rstn), .clk_en(clk_en), .wr(sel_tim),
    .wdata(wdata), .word(w_tim));
  dtp_word_reg u_ca (.core_clk(core_clk), .rstn(rstn), .clk_en(clk_en), .wr(sel_ca),
    .wdata(wdata), .word(w_ca));
  dtp_word_reg u_ctl (.core_clk(core_clk), .rstn(rstn), .clk_en(clk_en), .wr(sel_ctl),
    .wdata(wdata), .word(w_ctl));
  dtp_word_reg u_ck (.core_clk(core_clk), .rstn(rstn), .clk_en(clk_en), .wr(sel_ck),
    .wdata(wdata), .word(w_ck));
  dtp_word_reg u_xt (.core_clk(core_clk), .rstn(rstn), .clk_en(clk_en), .wr(sel_xt),
    .wdata(wdata), .word(w_xt));
  dtp_word_reg u_pwr (.core_clk(core_clk), .rstn(rstn), .clk_en(clk_en), .wr(sel_pwr),
    .wdata(wdata), .word(w_pwr));

  // two-bit strength code to level
  function automatic dtp_drive_t drv3(input logic [1:0] c);
    case (c)
      2'h0: drv3 = DTP_LIGHT;
      2'h1: drv3 = DTP_MODERATE;
      2'h2: drv3 = DTP_STRONG;
      default: drv3 = DTP_RESERVED;
    endcase
  endfunction

  // control outputs only have light and moderate
  function automatic dtp_drive_t drv2(input logic [1:0] c);
    case (c)
      2'h0: drv2 = DTP_LIGHT;
      2'h1: drv2 = DTP_MODERATE;
      default: drv2 = DTP_RESERVED;
    endcase
  endfunction

  wire dtp_drive_t next_ca_drive_a = drv3(w_ca[`DTP_LO_PAIR]);
  wire dtp_drive_t next_ca_drive_b = drv3(w_ca[`DTP_HI_PAIR]);
  wire dtp_drive_t next_ctl_drive_a = drv2(w_ctl[`DTP_LO_PAIR]);
  wire dtp_drive_t next_ctl_drive_b = drv2(w_ctl[`DTP_HI_PAIR]);
  wire dtp_drive_t next_clk_drive_13 = drv3(w_ck[`DTP_LO_PAIR]);
  wire dtp_drive_t next_clk_drive_02 = drv3(w_ck[`DTP_HI_PAIR]);

  // termination value selection
  wire [2:0] xt_low = w_xt[`DTP_XT_LOW];
  dtp_term_t next_term_value;
  // extra word value select, timing word fallback
  always_comb begin
    case (xt_low)
      `DTP_XT_DEFAULT: next_term_value = w_tim[`DTP_TIM_TERM] ? DTP_T_150 : DTP_T_100;
      `DTP_XT_200: next_term_value = DTP_T_200;
      `DTP_XT_300: next_term_value = DTP_T_300;
      `DTP_XT_OFF: next_term_value = DTP_T_OFF;
      default: next_term_value = DTP_T_RSVD;
    endcase
  end

  // power-down state
  // enable bit gates everything, both enables low
  wire pd_en = w_pwr[`DTP_PWR_PD_EN];
  wire next_power_down = pd_en && !clock_enable_in_0 && !clock_enable_in_1;
  wire pd_term_off = next_power_down && w_pwr[`DTP_PWR_ODT_OFF];

  // termination enables
  // mirror bit, only honoured with low bits clear
  wire mirror_kill = mirror && !(w_xt[`DTP_XT_MIRROR] && (xt_low == `DTP_XT_DEFAULT));
  // mirror spares select and odt inputs
  wire next_term_main_en = !mirror_kill && (xt_low != `DTP_XT_OFF) && !pd_term_off;
  // all-ones turns off select and odt too, power-down off
  wire next_term_sel_odt_en = (xt_low != `DTP_XT_OFF) && !pd_term_off;
  // odt outputs held low in power-down with termination off
  wire next_term_enable_outputs = pd_term_off ? 1'b0 : term_enable_input_pins;

  // pre-launch request from the timing word
  wire next_ca_prelaunch = w_tim[`DTP_TIM_PRELAUNCH];
  wire glb_float = w_glb[`DTP_GLB_FLOAT];
  // weak drive select, only with float enabled
  wire next_weak_drive = glb_float && w_pwr[`DTP_PWR_WEAK];
  wire next_ca_float_idle = glb_float && !w_pwr[`DTP_PWR_WEAK];

  // output registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ca_drive_a <= DTP_LIGHT;
      ca_drive_b <= DTP_LIGHT;
      ctl_drive_a <= DTP_LIGHT;
      ctl_drive_b <= DTP_LIGHT;
      clk_drive_13 <= DTP_LIGHT;
      clk_drive_02 <= DTP_LIGHT;
      term_value <= DTP_T_100;
      term_main_en <= 1'b1;
      term_sel_odt_en <= 1'b1;
      ca_prelaunch <= 1'b0;
      ca_float_idle <= 1'b0;
      weak_drive <= 1'b0;
      power_down <= 1'b0;
      term_enable_outputs <= 1'b0;
    end else if (clk_en) begin
      ca_drive_a <= next_ca_drive_a;
      ca_drive_b <= next_ca_drive_b;
      ctl_drive_a <= next_ctl_drive_a;
      ctl_drive_b <= next_ctl_drive_b;
      clk_drive_13 <= next_clk_drive_13;
      clk_drive_02 <= next_clk_drive_02;
      term_value <= next_term_value;
      term_main_en <= next_term_main_en;
      term_sel_odt_en <= next_term_sel_odt_en;
      ca_prelaunch <= next_ca_prelaunch;
      ca_float_idle <= next_ca_float_idle;
      weak_drive <= next_weak_drive;
      power_down <= next_power_down;
      term_enable_outputs <= next_term_enable_outputs;
    end
  end

  // checks
  sequence s_cw_write_addr_ca;
    clk_en && sel_ca;
  endsequence
  property p_ca_drive;
    @(posedge core_clk) disable iff (!rstn)
    s_cw_write_addr_ca ##1 clk_en |=> ca_drive_a == drv3($past(wdata[1:0], 2));
  endproperty
  a_ca_drive: assert property (p_ca_drive) else $error("address a strength wrong");
  property p_ca_drive_b;
    @(posedge core_clk) disable iff (!rstn)
    s_cw_write_addr_ca ##1 clk_en |=> ca_drive_b == drv3($past(wdata[3:2], 2));
  endproperty
  a_ca_drive_b: assert property (p_ca_drive_b) else $error("address b strength wrong");
  property p_ctl_no_strong;
    @(posedge core_clk) disable iff (!rstn)
    ctl_drive_a != DTP_STRONG && ctl_drive_b != DTP_STRONG;
  endproperty
  a_ctl_no_strong: assert property (p_ctl_no_strong) else $error("control strong");
  sequence s_cw_write_addr_ck;
    clk_en && sel_ck;
  endsequence
  property p_clk_drive;
    @(posedge core_clk) disable iff (!rstn)
    s_cw_write_addr_ck ##1 clk_en |=> clk_drive_02 == drv3($past(wdata[`DTP_HI_PAIR], 2));
  endproperty
  a_clk_drive: assert property (p_clk_drive) else $error("clock strength wrong");
  property p_xt_off;
    @(posedge core_clk) disable iff (!rstn)
    clk_en && xt_low == `DTP_XT_OFF |=> !term_main_en && !term_sel_odt_en;
  endproperty
  a_xt_off: assert property (p_xt_off) else $error("termination not off");
  property p_mirror;
    @(posedge core_clk) disable iff (!rstn)
    clk_en && mirror && !w_xt[`DTP_XT_MIRROR] |=> !term_main_en;
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror termination on");
  property p_pd_disabled;
    @(posedge core_clk) disable iff (!rstn)
    clk_en && !pd_en |=> !power_down;
  endproperty
  a_pd_disabled: assert property (p_pd_disabled) else $error("power-down while disabled");
  property p_pd_entry;
    @(posedge core_clk) disable iff (!rstn)
    clk_en && pd_en && !clock_enable_in_0 && !clock_enable_in_1 |=> power_down;
  endproperty
  a_pd_entry: assert property (p_pd_entry) else $error("power-down not entered");
  property p_odt_low;
    @(posedge core_clk) disable iff (!rstn)
    clk_en && pd_term_off |=> !term_enable_outputs && !term_sel_odt_en;
  endproperty
  a_odt_low: assert property (p_odt_low) else $error("odt not held low");
  property p_weak;
    @(posedge core_clk) disable iff (!rstn)
    weak_drive |-> $past(glb_float);
  endproperty
  a_weak: assert property (p_weak) else $error("weak drive without float");

  // drive strength checks for the remaining pairs
  sequence s_cw_write_addr_ctl;
    clk_en && sel_ctl;
  endsequence
  property p_ctl_drive_a;
    @(posedge core_clk) disable iff (!rstn)
    s_cw_write_addr_ctl ##1 clk_en |=> ctl_drive_a == drv2($past(wdata[`DTP_LO_PAIR], 2));
  endproperty
  a_ctl_drive_a: assert property (p_ctl_drive_a) else $error("control a drive wrong");
  property p_ctl_drive_b;
    @(posedge core_clk) disable iff (!rstn)
    s_cw_write_addr_ctl ##1 clk_en |=> ctl_drive_b == drv2($past(wdata[`DTP_HI_PAIR], 2));
  endproperty
  a_ctl_drive_b: assert property (p_ctl_drive_b) else $error("control b drive wrong");
  property p_clk_drive_13;
    @(posedge core_clk) disable iff (!rstn)
    s_cw_write_addr_ck ##1 clk_en |=> clk_drive_13 == drv3($past(wdata[`DTP_LO_PAIR], 2));
  endproperty
  a_clk_drive_13: assert property (p_clk_drive_13) else $error("clock 1/3 drive wrong");

  // termination value and enable checks
  property p_xt_200;
    @(posedge core_clk) disable iff (!rstn)
    clk_en && xt_low == `DTP_XT_200 |=> term_value == DTP_T_200;
  endproperty
  a_xt_200: assert property (p_xt_200) else $error("termination not 200");
  property p_xt_300;
    @(posedge core_clk) disable iff (!rstn)
    clk_en && xt_low == `DTP_XT_300 |=> term_value == DTP_T_300;
  endproperty
  a_xt_300: assert property (p_xt_300) else $error("termination not 300");
  property p_tim_term;
    @(posedge core_clk) disable iff (!rstn)
    clk_en && xt_low == `DTP_XT_DEFAULT |=>
      term_value == ($past(w_tim[`DTP_TIM_TERM]) ? DTP_T_150 : DTP_T_100);
  endproperty
  a_tim_term: assert property (p_tim_term) else $error("timing word value lost");
  // mirror-on bit only counts with the low bits clear
  property p_mirror_on;
    @(posedge core_clk) disable iff (!rstn)
    clk_en && mirror && w_xt[`DTP_XT_MIRROR] && xt_low == `DTP_XT_DEFAULT
      && !pd_term_off |=> term_main_en;
  endproperty
  a_mirror_on: assert property (p_mirror_on) else $error("mirror-on ignored");
  property p_mirror_bits;
    @(posedge core_clk) disable iff (!rstn)
    clk_en && mirror && xt_low != `DTP_XT_DEFAULT |=> !term_main_en;
  endproperty
  a_mirror_bits: assert property (p_mirror_bits) else $error("mirror kept on");
  property p_sel_mirror;
    @(posedge core_clk) disable iff (!rstn)
    clk_en && mirror && xt_low != `DTP_XT_OFF && !pd_term_off |=> term_sel_odt_en;
  endproperty
  a_sel_mirror: assert property (p_sel_mirror) else $error("select term off");

  // timing, float and power-down checks
  property p_prelaunch;
    @(posedge core_clk) disable iff (!rstn)
    clk_en |=> ca_prelaunch == $past(w_tim[`DTP_TIM_PRELAUNCH]);
  endproperty
  a_prelaunch: assert property (p_prelaunch) else $error("pre-launch wrong");
  property p_float_idle;
    @(posedge core_clk) disable iff (!rstn)
    clk_en && glb_float && !w_pwr[`DTP_PWR_WEAK] |=> ca_float_idle && !weak_drive;
  endproperty
  a_float_idle: assert property (p_float_idle) else $error("float not applied");
  property p_weak_on;
    @(posedge core_clk) disable iff (!rstn)
    clk_en && glb_float && w_pwr[`DTP_PWR_WEAK] |=> weak_drive && !ca_float_idle;
  endproperty
  a_weak_on: assert property (p_weak_on) else $error("weak drive not applied");
  property p_pd_odt_follow;
    @(posedge core_clk) disable iff (!rstn)
    clk_en && !pd_term_off |=> term_enable_outputs == $past(term_enable_input_pins);
  endproperty
  a_pd_odt_follow: assert property (p_pd_odt_follow) else $error("odt not following");
  property p_pd_exit;
    @(posedge core_clk) disable iff (!rstn)
    clk_en && (clock_enable_in_0 || clock_enable_in_1) |=> !power_down;
  endproperty
  a_pd_exit: assert property (p_pd_exit) else $error("power-down with enable high");
endmodule // dtp_config

// [rtl/dtp_consts.svh]
// address, bit-position and code constants for the drive/termination/power config block
`ifndef DTP_CONSTS_SVH
`define DTP_CONSTS_SVH
`define DTP_ADDR_GLOBAL 4'h0
`define DTP_ADDR_TIMING 4'h2
`define DTP_ADDR_CA_DRV 4'h3
`define DTP_ADDR_CTL_DRV 4'h4
`define DTP_ADDR_CK_DRV 4'h5
`define DTP_ADDR_XTERM 4'h8
`define DTP_ADDR_PWR 4'h9
`define DTP_WORD_RESET 4'h0
`define DTP_GLB_FLOAT 1
`define DTP_TIM_PRELAUNCH 0
`define DTP_TIM_TERM 2
`define DTP_XT_MIRROR 3
`define DTP_PWR_WEAK 0
`define DTP_PWR_ODT_OFF 2
`define DTP_PWR_PD_EN 3
`define DTP_XT_DEFAULT 3'h0
`define DTP_XT_200 3'h2
`define DTP_XT_300 3'h4
`define DTP_XT_OFF 3'h7
`define DTP_LO_PAIR 1:0
`define DTP_HI_PAIR 3:2
`define DTP_XT_LOW 2:0
`endif

// [rtl/dtp_pkg.sv]
// types shared by the configuration block
package dtp_pkg;
  typedef enum logic [1:0] {DTP_LIGHT, DTP_MODERATE, DTP_STRONG, DTP_RESERVED} dtp_drive_t;
  typedef enum logic [2:0] {DTP_T_OFF, DTP_T_100, DTP_T_150, DTP_T_200, DTP_T_300,
    DTP_T_RSVD} dtp_term_t;
endpackage

// [rtl/dtp_word_reg.sv]
// one 4-bit write-only control word with hold-on-write storage
`include "dtp_consts.svh"
module dtp_word_reg (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // write port
  input wire logic wr,
  input wire logic [3:0] wdata,
  // stored word
  output logic [3:0] word
);
  import dtp_pkg::*;
  // load on select
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      word <= `DTP_WORD_RESET;
    end else if (clk_en && wr) begin
      word <= wdata;
    end
  end
endmodule // dtp_word_reg

// [tb/dtp_ctrl_model.sv]
// controller model writing control words over the command inputs
module dtp_ctrl_model (
  // clock
  input wire logic core_clk,
  // control word write
  output logic cw_write,
  output logic [3:0] cw_addr,
  output logic cw_data_bit0,
  output logic cw_data_bit1,
  output logic cw_data_bit2,
  output logic cw_data_bit3
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus at time zero
  initial begin
    cw_write = 1'b0;
    cw_addr = 4'h0;
    {cw_data_bit3, cw_data_bit2, cw_data_bit1, cw_data_bit0} = 4'h0;
  end

  // any address and data, no check for valid codes
  // one write: held over one rising edge, then released lines show inverted garbage
  task automatic write_word(input logic [3:0] addr, input logic [3:0] data);
    @(negedge core_clk);
    cw_write = 1'b1;
    cw_addr = addr;
    {cw_data_bit3, cw_data_bit2, cw_data_bit1, cw_data_bit0} = data;
    @(negedge core_clk);
    cw_write = 1'b0;
    cw_addr = ~addr;
    {cw_data_bit3, cw_data_bit2, cw_data_bit1, cw_data_bit0} = ~data;
  endtask
endmodule // dtp_ctrl_model

// [tb/tb_top.sv]
// self-checking testbench for the control word decode block
`include "dtp_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dtp_pkg::*;

  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic clk_en = 1'b1;
  logic mirror = 1'b0;
  logic clock_enable_in_0 = 1'b1;
  logic clock_enable_in_1 = 1'b1;
  logic term_enable_input_pins = 1'b0;
  logic cw_write, cw_data_bit0, cw_data_bit1, cw_data_bit2, cw_data_bit3;
  logic [3:0] cw_addr;
  dtp_drive_t ca_drive_a, ca_drive_b, ctl_drive_a, ctl_drive_b, clk_drive_13, clk_drive_02;
  dtp_term_t term_value;
  logic term_main_en, term_sel_odt_en, ca_prelaunch, ca_float_idle;
  logic weak_drive, power_down, term_enable_outputs;
  int bad_count = 0;
  int num_checks = 0;
  // strength levels in code order
  dtp_drive_t lvl [3] = '{DTP_LIGHT, DTP_MODERATE, DTP_STRONG};

  // clock generator
  always #20 core_clk = ~core_clk;

  dtp_ctrl_model dtp_ctrl_model_inst (.core_clk, .cw_write, .cw_addr, .cw_data_bit0,
    .cw_data_bit1, .cw_data_bit2, .cw_data_bit3);

  dtp_config dtp_config_inst (.core_clk, .rstn, .clk_en, .cw_write, .cw_addr,
    .cw_data_bit0, .cw_data_bit1, .cw_data_bit2, .cw_data_bit3, .mirror,
    .clock_enable_in_0, .clock_enable_in_1, .term_enable_input_pins, .ca_drive_a,
    .ca_drive_b, .ctl_drive_a, .ctl_drive_b, .clk_drive_13, .clk_drive_02, .term_value,
    .term_main_en, .term_sel_odt_en, .ca_prelaunch, .ca_float_idle, .weak_drive,
    .power_down, .term_enable_outputs);

  // compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // write a word, then let the decoded outputs land
  task automatic wr(input logic [3:0] addr, input logic [3:0] data);
    dtp_ctrl_model_inst.write_word(addr, data);
    @(negedge core_clk);
  endtask

  // one edge for pin inputs
  task automatic step;
    @(negedge core_clk);
  endtask

  task automatic test_end(input string name);
    $display("test done: %s", name);
  endtask

  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    #2_000_000;
    bad_count++;
    complete_run();
  end

  // main sequence
  initial begin
    repeat (16) @(negedge core_clk);
    rstn = 1'b1;
    step();
    chk(8'(ca_drive_a), 8'(DTP_LIGHT));
    chk(8'(term_value), 8'(DTP_T_100));
    chk(8'(term_main_en), 8'h01);
    chk(8'(ca_prelaunch), 8'h00);
    chk(8'(power_down), 8'h00);
    test_end("reset");
    // every valid strength code on both pairs
    for (int i = 0; i < 3; i++) begin
      wr(`DTP_ADDR_CA_DRV, {2'(2 - i), 2'(i)});
      wr(`DTP_ADDR_CK_DRV, {2'(2 - i), 2'(i)});
      chk(8'(ca_drive_a), 8'(lvl[i]));
      chk(8'(ca_drive_b), 8'(lvl[2 - i]));
      chk(8'(clk_drive_13), 8'(lvl[i]));
      chk(8'(clk_drive_02), 8'(lvl[2 - i]));
    end
    for (int i = 0; i < 2; i++) begin
      wr(`DTP_ADDR_CTL_DRV, {2'(1 - i), 2'(i)});
      chk(8'(ctl_drive_a), 8'(lvl[i]));
      chk(8'(ctl_drive_b), 8'(lvl[1 - i]));
    end
    // unmapped word and frozen clock enable leave strengths alone
    wr(4'h6, 4'h5);
    chk(8'(ca_drive_a), 8'(DTP_STRONG));
    clk_en = 1'b0;
    wr(`DTP_ADDR_CA_DRV, 4'h0);
    clk_en = 1'b1;
    chk(8'(ca_drive_a), 8'(DTP_STRONG));
    chk(8'(clk_drive_13), 8'(DTP_STRONG));
    test_end("drive");
    wr(`DTP_ADDR_TIMING, 4'h5);
    chk(8'(ca_prelaunch), 8'h01);
    chk(8'(term_value), 8'(DTP_T_150));
    wr(`DTP_ADDR_XTERM, 4'h2);
    chk(8'(term_value), 8'(DTP_T_200));
    wr(`DTP_ADDR_XTERM, 4'h4);
    chk(8'(term_value), 8'(DTP_T_300));
    wr(`DTP_ADDR_XTERM, 4'h0);
    chk(8'(term_value), 8'(DTP_T_150));
    mirror = 1'b1;
    step();
    chk(8'(term_main_en), 8'h00);
    chk(8'(term_sel_odt_en), 8'h01);
    wr(`DTP_ADDR_XTERM, 4'h8);
    chk(8'(term_main_en), 8'h01);
    wr(`DTP_ADDR_XTERM, 4'hA);
    chk(8'(term_main_en), 8'h00);
    chk(8'(term_sel_odt_en), 8'h01);
    chk(8'(term_value), 8'(DTP_T_200));
    wr(`DTP_ADDR_XTERM, 4'hF);
    chk(8'(term_sel_odt_en), 8'h00);
    chk(8'(term_value), 8'(DTP_T_OFF));
    mirror = 1'b0;
    step();
    chk(8'(term_main_en), 8'h00);
    chk(8'(term_sel_odt_en), 8'h00);
    wr(`DTP_ADDR_XTERM, 4'h0);
    chk(8'(term_main_en), 8'h01);
    test_end("termination");
    wr(`DTP_ADDR_PWR, 4'h1);
    chk(8'(weak_drive), 8'h00);
    wr(`DTP_ADDR_GLOBAL, 4'h2);
    chk(8'(weak_drive), 8'h01);
    chk(8'(ca_float_idle), 8'h00);
    wr(`DTP_ADDR_PWR, 4'h0);
    chk(8'(ca_float_idle), 8'h01);
    chk(8'(weak_drive), 8'h00);
    test_end("float");
    clock_enable_in_0 = 1'b0;
    clock_enable_in_1 = 1'b0;
    wr(`DTP_ADDR_PWR, 4'h4);
    chk(8'(power_down), 8'h00);
    chk(8'(term_main_en), 8'h01);
    wr(`DTP_ADDR_PWR, 4'h8);
    chk(8'(power_down), 8'h01);
    chk(8'(term_main_en), 8'h01);
    chk(8'(term_sel_odt_en), 8'h01);
    term_enable_input_pins = 1'b1;
    step();
    chk(8'(term_enable_outputs), 8'h01);
    term_enable_input_pins = 1'b0;
    step();
    chk(8'(term_enable_outputs), 8'h00);
    term_enable_input_pins = 1'b1;
    wr(`DTP_ADDR_PWR, 4'hC);
    chk(8'(term_enable_outputs), 8'h00);
    chk(8'(term_main_en), 8'h00);
    chk(8'(term_sel_odt_en), 8'h00);
    clock_enable_in_0 = 1'b1;
    step();
    chk(8'(power_down), 8'h00);
    chk(8'(term_enable_outputs), 8'h01);
    test_end("power down");
    // reset in mid-run brings every word back to its default
    rstn = 1'b0;
    step();
    chk(8'(ca_drive_a), 8'(DTP_LIGHT));
    chk(8'(term_enable_outputs), 8'h00);
    rstn = 1'b1;
    step();
    chk(8'(term_value), 8'(DTP_T_100));
    chk(8'(ca_float_idle), 8'h00);
    chk(8'(term_enable_outputs), 8'h01);
    wr(`DTP_ADDR_CA_DRV, 4'h1);
    chk(8'(ca_drive_a), 8'(DTP_MODERATE));
    chk(8'(ca_drive_b), 8'(DTP_LIGHT));
    test_end("second reset");
    complete_run();
  end
endmodule // tb_top
